// ===== hdl/input_pll_divider_pump_config.sv
`timescale 1ns/10ps
module input_pll_divider_pump_config
(
    input  wire logic                                  clk,
    input  wire logic                                  sys_rst,
    input  wire logic [input_loop_cfg_pkg::ADDR_W-1:0] regAddr,
    input  wire logic                                  regWrite,
    input  wire logic                                  regRead,
    input  wire logic [input_loop_cfg_pkg::DATA_W-1:0] regWrData,
    input  wire logic                                  ioUpdate,
    input  wire logic                                  secondRefIndependent,
    input  wire logic                                  firstRefTick,
    input  wire logic                                  secondRefTick,
    input  wire logic                                  testRefTick,
    input  wire logic                                  feedbackTick,
    output logic      [input_loop_cfg_pkg::DATA_W-1:0] regRdData,
    output logic                                       regRdValid,
    output logic      [input_loop_cfg_pkg::DIV_W-1:0]  firstRefDivisor,
    output logic      [input_loop_cfg_pkg::DIV_W-1:0]  secondRefDivisor,
    output logic      [input_loop_cfg_pkg::DIV_W-1:0]  testRefDivisor,
    output logic      [input_loop_cfg_pkg::DIV_W-1:0]  feedbackDivisor,
    output logic                                       firstRefPulse,
    output logic                                       secondRefPulse,
    output logic                                       testRefPulse,
    output logic                                       feedbackPulse,
    output logic                                       pumpHighZ,
    output logic      [input_loop_cfg_pkg::CURRENT_W-1:0] pumpCurrent,
    output logic      [1:0]                            pumpMode,
    output logic                                       backlashManual,
    output logic      [1:0]                            backlashWidth
);
    import input_loop_cfg_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [REG_COUNT-1:0][DATA_W-1:0] pend;
        logic [REG_COUNT-1:0][DATA_W-1:0] act;
        logic                             rbSel;
        logic [DATA_W-1:0]                rdData;
        logic                             rdValid;
        logic [DIV_COUNT-1:0][DIV_W-1:0]  cnt;
        logic [DIV_COUNT-1:0][DIV_W-1:0]  div;
        logic [DIV_COUNT-1:0]             pulse;
        logic                             highZ;
        logic [CURRENT_W-1:0]             current;
        logic [1:0]                       mode;
        logic                             blManual;
        logic [1:0]                       blWidth;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    // codes 0 and 1 both divide by one
    function automatic div_t effDiv(input div_t code);
        effDiv = (code < div_t'(2)) ? div_t'(1) : code;
    endfunction : effDiv

    logic [DIV_COUNT-1:0] tick;
    assign tick = {feedbackTick, testRefTick, secondRefTick, firstRefTick};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        div_t   firstCode;
        div_t   secondCode;
        div_t   testCode;
        div_t   fbCode;
        logic   hit;
        byte_t  rd;
        nxt_st     = st_ff;
        hit        = 1'b0;
        rd         = '0;
        firstCode  = '0;
        secondCode = '0;
        testCode   = '0;
        fbCode     = '0;
        nxt_st.pulse   = '0;
        nxt_st.rdValid = regRead;
        if (regWrite && regAddr == OFF_READBACK_SEL) begin
            nxt_st.rbSel = regWrData[BIT_READBACK_SEL];
        end
        for (int i = 0; i < REG_COUNT; i++) begin
            if (regWrite && regAddr == REG_OFFS[i]) begin
                nxt_st.pend[i] = regWrData & REG_MASK[i];
            end
            if (regAddr == REG_OFFS[i]) begin
                hit = 1'b1;
                rd  = st_ff.rbSel ? st_ff.pend[i] : st_ff.act[i];
            end
        end
        if (regAddr == OFF_READBACK_SEL) begin
            hit = 1'b1;
            rd  = byte_t'(st_ff.rbSel);
        end
        // unmapped addresses read zero
        if (regRead) begin
            nxt_st.rdData = hit ? rd : '0;
        end
        if (ioUpdate) begin
            nxt_st.act = nxt_st.pend;
        end
        firstCode  = {nxt_st.act[IDX_R1_HIGH][1:0], nxt_st.act[IDX_R1_LOW]};
        secondCode = {nxt_st.act[IDX_R2_HIGH][1:0], nxt_st.act[IDX_R2_LOW]};
        testCode   = div_t'(nxt_st.act[IDX_TEST][TEST_DIV_W-1:0]);
        fbCode     = {nxt_st.act[IDX_FB_HIGH][1:0], nxt_st.act[IDX_FB_LOW]};
        nxt_st.div[0] = effDiv(firstCode);
        nxt_st.div[1] = secondRefIndependent ? effDiv(secondCode) : effDiv(firstCode);
        nxt_st.div[2] = effDiv(testCode);
        nxt_st.div[3] = effDiv(fbCode);
        for (int d = 0; d < DIV_COUNT; d++) begin
            if (tick[d]) begin
                if (st_ff.cnt[d] >= st_ff.div[d] - div_t'(1)) begin
                    nxt_st.cnt[d]   = '0;
                    nxt_st.pulse[d] = 1'b1;
                end else begin
                    nxt_st.cnt[d] = st_ff.cnt[d] + div_t'(1);
                end
            end
        end
        nxt_st.highZ    = nxt_st.act[IDX_PUMP][BIT_PUMP_HIGHZ];
        nxt_st.current  = nxt_st.act[IDX_PUMP][CURRENT_W-1:0];
        nxt_st.mode     = nxt_st.act[IDX_MODE][MODE_LSB+:2];
        nxt_st.blManual = nxt_st.act[IDX_MODE][BIT_BL_MANUAL];
        nxt_st.blWidth  = nxt_st.blManual ? nxt_st.act[IDX_MODE][BL_WIDTH_LSB+:2] : BL_HIGH;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                st_ff.pend[i] <= REG_RST[i];
                st_ff.act[i]  <= REG_RST[i];
            end
            st_ff.rbSel    <= 1'b0;
            st_ff.rdData   <= '0;
            st_ff.rdValid  <= 1'b0;
            st_ff.cnt      <= '0;
            st_ff.div      <= {DIV_COUNT{div_t'(1)}};
            st_ff.pulse    <= '0;
            st_ff.highZ    <= 1'b0;
            st_ff.current  <= '0;
            st_ff.mode     <= MODE_NORMAL;
            st_ff.blManual <= 1'b0;
            st_ff.blWidth  <= BL_HIGH;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flops; the tag bytes drive nothing
    assign regRdData        = st_ff.rdData;
    assign regRdValid       = st_ff.rdValid;
    assign firstRefDivisor  = st_ff.div[0];
    assign secondRefDivisor = st_ff.div[1];
    assign testRefDivisor   = st_ff.div[2];
    assign feedbackDivisor  = st_ff.div[3];
    assign firstRefPulse    = st_ff.pulse[0];
    assign secondRefPulse   = st_ff.pulse[1];
    assign testRefPulse     = st_ff.pulse[2];
    assign feedbackPulse    = st_ff.pulse[3];
    assign pumpHighZ        = st_ff.highZ;
    assign pumpCurrent      = st_ff.current;
    assign pumpMode         = st_ff.mode;
    assign backlashManual   = st_ff.blManual;
    assign backlashWidth    = st_ff.blWidth;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence tagWrite;
        regWrite && !ioUpdate && (regAddr == OFF_USER_TAG_LOW || regAddr == OFF_USER_TAG_HIGH);
    endsequence
    sequence pumpHighZWrite;
        regWrite && regAddr == OFF_PUMP_CURRENT && regWrData[BIT_PUMP_HIGHZ] && !ioUpdate;
    endsequence
    sequence quietUpdate;
        ioUpdate && !regWrite;
    endsequence
    sequence gapUpdate;
        !regWrite ##1 quietUpdate;
    endsequence
    sequence pumpWrite;
        regWrite && regAddr == OFF_PUMP_CURRENT && !ioUpdate;
    endsequence
    sequence modeWrite;
        regWrite && regAddr == OFF_PUMP_MODE_BACKLASH && !ioUpdate;
    endsequence

    a_tag_inert: assert property (tagWrite |=> $stable(firstRefDivisor) && $stable(pumpMode))
        else $error("user tag write changed loop settings");
    a_div_nonzero: assert property (firstRefDivisor != '0 && feedbackDivisor != '0)
        else $error("divisor reached zero");
    a_second_follow: assert property (!secondRefIndependent |=> secondRefDivisor == firstRefDivisor)
        else $error("second divisor not following first");
    a_test_range: assert property (testRefDivisor >= div_t'(1) && testRefDivisor <= div_t'(63))
        else $error("test divisor out of range");
    a_pump_highz: assert property (pumpHighZWrite ##1 gapUpdate |=> pumpHighZ)
        else $error("pump not tristated after update");
    a_backlash_auto: assert property (!backlashManual |-> backlashWidth == BL_HIGH)
        else $error("auto backlash width not high");
    a_mode_reset: assert property (disable iff (1'b0) sys_rst |=> pumpMode == MODE_NORMAL)
        else $error("pump mode not normal after reset");
    a_spare_zero: assert property (regRead && regAddr == OFF_LOOP_SPARE |=> regRdData == '0)
        else $error("reserved register read nonzero");
    a_rb_pending: assert property (regWrite && regAddr == OFF_USER_TAG_LOW && st_ff.rbSel ##1 !regWrite
        ##1 regRead && regAddr == OFF_USER_TAG_LOW && !regWrite |=> regRdData == $past(regWrData, 3))
        else $error("pending readback mismatch");
    a_fb_by_one: assert property (feedbackTick && feedbackDivisor == div_t'(1) |=> feedbackPulse)
        else $error("feedback divide-by-one missed pulse");

    // ------------------------------------------------------------
    // checks: read port
    // ------------------------------------------------------------
    // read answered
    a_read_valid: assert property (regRead |=> regRdValid)
        else $error("read not answered next cycle");
    a_valid_pulse: assert property (!regRead |=> !regRdValid)
        else $error("read valid without a read");
    a_read_reset: assert property (disable iff (1'b0) sys_rst |=> !regRdValid && regRdData == '0)
        else $error("read port not cleared by reset");
    a_rbsel_write: assert property (regWrite && regAddr == OFF_READBACK_SEL
        |=> st_ff.rbSel == $past(regWrData[BIT_READBACK_SEL]))
        else $error("readback select not taken");
    a_rbsel_read: assert property (regRead && regAddr == OFF_READBACK_SEL
        |=> regRdData == byte_t'($past(st_ff.rbSel)))
        else $error("readback select bit read wrong");
    a_active_read: assert property (regRead && regAddr == OFF_PUMP_CURRENT && !st_ff.rbSel
        |=> regRdData == {$past(pumpHighZ), $past(pumpCurrent)})
        else $error("active readback differs from pump outputs");
    a_pending_hold: assert property (regWrite && !ioUpdate
        |=> $stable(pumpCurrent) && $stable(pumpHighZ) && $stable(feedbackDivisor))
        else $error("write took effect without update");
    a_unmapped_zero: assert property (regRead && regAddr > OFF_PUMP_MODE_BACKLASH
        |=> regRdData == '0)
        else $error("unmapped address read nonzero");
    a_test_rsvd: assert property (regRead && regAddr == OFF_TEST_REF |=> regRdData[7:6] == 2'h0)
        else $error("test divisor reserved bits nonzero");
    a_mode_rsvd: assert property (regRead && regAddr == OFF_PUMP_MODE_BACKLASH
        |=> regRdData[7:5] == 3'h0)
        else $error("mode register reserved bits nonzero");
    a_high_rsvd: assert property (regRead && (regAddr == OFF_FIRST_REF_HIGH || regAddr == OFF_SECOND_REF_HIGH
        || regAddr == OFF_FEEDBACK_HIGH) |=> regRdData[7:2] == 6'h00)
        else $error("divisor high byte reserved bits nonzero");
    a_tag_reset: assert property (disable iff (1'b0) sys_rst
        |=> st_ff.act[IDX_TAG_LOW] == RST_USER_TAG && st_ff.act[IDX_TAG_HIGH] == RST_USER_TAG)
        else $error("user tag not cleared by reset");

    // ------------------------------------------------------------
    // checks: dividers
    // ------------------------------------------------------------
    // no tick, no pulse
    a_first_idle: assert property (!firstRefTick |=> !firstRefPulse)
        else $error("first reference pulse without tick");
    a_second_idle: assert property (!secondRefTick |=> !secondRefPulse)
        else $error("second reference pulse without tick");
    a_test_idle: assert property (!testRefTick |=> !testRefPulse)
        else $error("test reference pulse without tick");
    a_fb_idle: assert property (!feedbackTick |=> !feedbackPulse)
        else $error("feedback pulse without tick");
    a_second_by_one: assert property (secondRefTick && secondRefDivisor == div_t'(1) |=> secondRefPulse)
        else $error("second divide-by-one missed pulse");
    a_other_nonzero: assert property (secondRefDivisor != '0 && testRefDivisor != '0)
        else $error("second or test divisor reached zero");

    // ------------------------------------------------------------
    // checks: pump and backlash
    // ------------------------------------------------------------
    // tristate follows update
    a_highz_update: assert property (pumpWrite ##1 gapUpdate
        |=> pumpHighZ == $past(regWrData[BIT_PUMP_HIGHZ], 3))
        else $error("pump tristate not taken on update");
    a_current_update: assert property (pumpWrite ##1 gapUpdate
        |=> pumpCurrent == $past(regWrData[CURRENT_W-1:0], 3))
        else $error("pump current not taken on update");
    a_mode_update: assert property (modeWrite ##1 gapUpdate
        |=> pumpMode == $past(regWrData[MODE_LSB+:2], 3))
        else $error("pump mode not taken on update");
    a_manual_update: assert property (modeWrite ##1 gapUpdate
        |=> backlashManual == $past(regWrData[BIT_BL_MANUAL], 3))
        else $error("backlash select not taken on update");
    a_width_update: assert property (modeWrite ##1 gapUpdate
        |=> backlashWidth == ($past(regWrData[BIT_BL_MANUAL], 3) ? $past(regWrData[BL_WIDTH_LSB+:2], 3) : BL_HIGH))
        else $error("backlash width not taken on update");
    a_width_reset: assert property (disable iff (1'b0) sys_rst
        |=> backlashWidth == BL_HIGH && !backlashManual)
        else $error("backlash not at high auto after reset");

endmodule : input_pll_divider_pump_config

// ===== hdl/input_loop_cfg_pkg.sv
package input_loop_cfg_pkg;

    // ------------------------------------------------------------
    // register port geometry
    // ------------------------------------------------------------
    localparam int          ADDR_W    = 12;
    localparam int          DATA_W    = 8;
    localparam int          DIV_W     = 10;
    localparam int          REG_COUNT = 12;
    localparam int          DIV_COUNT = 4;

    // ------------------------------------------------------------
    // offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_READBACK_SEL        = 12'h004;
    localparam logic [11:0] OFF_USER_TAG_LOW        = 12'h005;
    localparam logic [11:0] OFF_USER_TAG_HIGH       = 12'h006;
    localparam logic [11:0] OFF_FIRST_REF_LOW       = 12'h010;
    localparam logic [11:0] OFF_FIRST_REF_HIGH      = 12'h011;
    localparam logic [11:0] OFF_SECOND_REF_LOW      = 12'h012;
    localparam logic [11:0] OFF_SECOND_REF_HIGH     = 12'h013;
    localparam logic [11:0] OFF_TEST_REF            = 12'h014;
    localparam logic [11:0] OFF_LOOP_SPARE          = 12'h015;
    localparam logic [11:0] OFF_FEEDBACK_LOW        = 12'h016;
    localparam logic [11:0] OFF_FEEDBACK_HIGH       = 12'h017;
    localparam logic [11:0] OFF_PUMP_CURRENT        = 12'h018;
    localparam logic [11:0] OFF_PUMP_MODE_BACKLASH  = 12'h019;

    // bank entries in index order
    localparam logic [11:0] REG_OFFS [REG_COUNT] = '{
        OFF_USER_TAG_LOW, OFF_USER_TAG_HIGH, OFF_FIRST_REF_LOW, OFF_FIRST_REF_HIGH,
        OFF_SECOND_REF_LOW, OFF_SECOND_REF_HIGH, OFF_TEST_REF, OFF_LOOP_SPARE,
        OFF_FEEDBACK_LOW, OFF_FEEDBACK_HIGH, OFF_PUMP_CURRENT, OFF_PUMP_MODE_BACKLASH};

    localparam int          IDX_TAG_LOW   = 0;
    localparam int          IDX_TAG_HIGH  = 1;
    localparam int          IDX_R1_LOW    = 2;
    localparam int          IDX_R1_HIGH   = 3;
    localparam int          IDX_R2_LOW    = 4;
    localparam int          IDX_R2_HIGH   = 5;
    localparam int          IDX_TEST      = 6;
    localparam int          IDX_SPARE     = 7;
    localparam int          IDX_FB_LOW    = 8;
    localparam int          IDX_FB_HIGH   = 9;
    localparam int          IDX_PUMP      = 10;
    localparam int          IDX_MODE      = 11;

    // writable bits; everything else reads zero
    localparam logic [7:0]  REG_MASK [REG_COUNT] = '{
        8'hFF, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'h03, 8'h3F, 8'h00, 8'hFF, 8'h03, 8'hFF, 8'h1F};

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_USER_TAG  = 8'h00;
    localparam logic [7:0]  RST_DIV_LOW   = 8'h01;
    localparam logic [7:0]  RST_ZERO      = 8'h00;
    localparam logic [7:0]  RST_PUMP      = 8'h00;
    localparam logic [7:0]  RST_MODE      = 8'h0B;
    localparam logic [7:0]  REG_RST [REG_COUNT] = '{
        RST_USER_TAG, RST_USER_TAG, RST_DIV_LOW, RST_ZERO, RST_DIV_LOW, RST_ZERO,
        RST_DIV_LOW, RST_ZERO, RST_DIV_LOW, RST_ZERO, RST_PUMP, RST_MODE};

    // ------------------------------------------------------------
    // field positions and codes
    // ------------------------------------------------------------
    localparam int          BIT_READBACK_SEL  = 0;
    localparam int          BIT_PUMP_HIGHZ    = 7;
    localparam int          BIT_BL_MANUAL     = 4;
    localparam int          BL_WIDTH_LSB      = 2;
    localparam int          MODE_LSB          = 0;
    localparam int          TEST_DIV_W        = 6;
    localparam int          CURRENT_W         = 7;
    localparam logic [1:0]  BL_MINIMUM        = 2'h0;
    localparam logic [1:0]  BL_LOW            = 2'h1;
    localparam logic [1:0]  BL_HIGH           = 2'h2;
    localparam logic [1:0]  BL_MAXIMUM        = 2'h3;
    localparam logic [1:0]  MODE_TRISTATE     = 2'h0;
    localparam logic [1:0]  MODE_PUMP_UP      = 2'h1;
    localparam logic [1:0]  MODE_PUMP_DOWN    = 2'h2;
    localparam logic [1:0]  MODE_NORMAL       = 2'h3;

    typedef logic [DATA_W-1:0] byte_t;
    typedef logic [DIV_W-1:0]  div_t;

endpackage : input_loop_cfg_pkg

// ===== dv/input_pll_divider_pump_config_test.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin failures++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module input_pll_divider_pump_config_test;
    import input_loop_cfg_pkg::*;
    // ------------------------------------------------------------
    // signals and bench model
    // ------------------------------------------------------------
    logic        clk, sys_rst, regWrite, regRead, ioUpdate, secondRefIndependent;
    logic        regRdValid, pumpHighZ, backlashManual, rbSel;
    logic [11:0] regAddr;
    logic [7:0]  regWrData, regRdData, d;
    logic [3:0]  tickV, pulseV;
    logic [9:0]  firstRefDivisor, secondRefDivisor, testRefDivisor, feedbackDivisor;
    logic [6:0]  pumpCurrent;
    logic [1:0]  pumpMode, backlashWidth;
    logic [7:0]  act [12];
    logic [7:0]  pend [12];
    int          failures, checkCount, selIdx, pcnt, i, k;
    // own copies, so a wrong package mask is caught
    localparam logic [7:0] MSK [12] = '{8'hFF, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'h03, 8'h3F, 8'h00, 8'hFF, 8'h03,
                                        8'hFF, 8'h1F};
    localparam logic [7:0] RSTV [12] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00,
                                         8'h00, 8'h0B};

    input_pll_divider_pump_config dut (
        .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWrData(regWrData), .ioUpdate(ioUpdate), .secondRefIndependent(secondRefIndependent),
        .firstRefTick(tickV[0]), .secondRefTick(tickV[1]), .testRefTick(tickV[2]), .feedbackTick(tickV[3]),
        .regRdData(regRdData), .regRdValid(regRdValid), .firstRefDivisor(firstRefDivisor),
        .secondRefDivisor(secondRefDivisor), .testRefDivisor(testRefDivisor), .feedbackDivisor(feedbackDivisor),
        .firstRefPulse(pulseV[0]), .secondRefPulse(pulseV[1]), .testRefPulse(pulseV[2]),
        .feedbackPulse(pulseV[3]), .pumpHighZ(pumpHighZ), .pumpCurrent(pumpCurrent), .pumpMode(pumpMode),
        .backlashManual(backlashManual), .backlashWidth(backlashWidth));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // free-running count; windows are measured as differences
    always @(posedge clk) pcnt <= pcnt + int'(pulseV[selIdx]);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [9:0] eff(logic [9:0] v);
        return (v <= 10'h001) ? 10'h001 : v;
    endfunction : eff

    task give_verdict;
        if (failures == 0 && checkCount > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task wr(logic [11:0] a, logic [7:0] v);
        @(posedge clk);
        regAddr <= a; regWrData <= v; regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        for (int j = 0; j < 12; j++) if (REG_OFFS[j] == a) pend[j] = v & MSK[j];
        if (a == OFF_READBACK_SEL) rbSel = v[0];
    endtask : wr

    task chk_out;
        logic [9:0] f;
        f = eff({act[3][1:0], act[2]});
        `CHK(firstRefDivisor, f)
        `CHK(secondRefDivisor, secondRefIndependent ? eff({act[5][1:0], act[4]}) : f)
        `CHK(testRefDivisor, eff({4'h0, act[6][5:0]}))
        `CHK(feedbackDivisor, eff({act[9][1:0], act[8]}))
        `CHK(pumpHighZ, act[10][7])
        `CHK(pumpCurrent, act[10][6:0])
        `CHK(pumpMode, act[11][1:0])
        `CHK(backlashManual, act[11][4])
        `CHK(backlashWidth, act[11][4] ? act[11][3:2] : 2'h2)
        `CHK(regRdValid, 1'b0)
    endtask : chk_out

    task upd;
        @(posedge clk);
        ioUpdate <= 1'b1;
        @(posedge clk);
        ioUpdate <= 1'b0;
        act = pend;
        #1 chk_out();
    endtask : upd

    task rd(logic [11:0] a);
        logic [7:0] e;
        e = (a == OFF_READBACK_SEL) ? {7'h00, rbSel} : 8'h00;
        for (int j = 0; j < 12; j++) if (REG_OFFS[j] == a) e = rbSel ? pend[j] : act[j];
        @(posedge clk);
        regAddr <= a; regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        `CHK(regRdValid, 1'b1)
        `CHK(regRdData, e)
    endtask : rd

    task div_chk(int idx, int n);
        int p0;
        selIdx = idx;
        // warm-up brings the counter below n whatever it held
        for (int c = 0; c < 4 * n + 2; c++) begin
            @(posedge clk);
            tickV <= (c < n || (c >= n + 2 && c < 4 * n + 2)) ? (4'h1 << idx) : 4'h0;
            if (c == n + 2) p0 = pcnt;
        end
        @(posedge clk);
        tickV <= 4'h0;
        repeat (2) @(posedge clk);
        `CHK(pcnt - p0, 3)
    endtask : div_chk

    initial begin
        #(50 * 30000);
        failures++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1; regWrite = 1'b0; regRead = 1'b0; ioUpdate = 1'b0; secondRefIndependent = 1'b0;
        regAddr = 12'h000; regWrData = 8'h00; tickV = 4'h0; pcnt = 0; selIdx = 0;
        failures = 0; checkCount = 0; rbSel = 1'b0;
        act = RSTV;
        pend = RSTV;
        void'($urandom(32'h0bcc1069));
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1 chk_out();
        for (i = 0; i < 12; i++) rd(REG_OFFS[i]);
        wr(OFF_READBACK_SEL, 8'h01);
        for (i = 0; i < 12; i++) rd(REG_OFFS[i]);
        for (k = 0; k < 4; k++) begin
            wr(OFF_PUMP_MODE_BACKLASH, {3'h7, 1'b1, k[1:0], k[1:0]});
            upd();
        end
        // auto mode ignores the width field
        wr(OFF_PUMP_MODE_BACKLASH, 8'h03);
        upd();
        wr(OFF_PUMP_CURRENT, 8'h80);
        upd();
        wr(OFF_PUMP_CURRENT, 8'h7F);
        upd();
        // tag must leave every output alone
        wr(OFF_USER_TAG_LOW, 8'hA5);
        rd(OFF_USER_TAG_LOW);
        wr(OFF_USER_TAG_HIGH, 8'h5A);
        upd();
        wr(OFF_LOOP_SPARE, 8'hFF);
        rd(OFF_LOOP_SPARE);
        rd(12'h020);
        repeat (60) begin
            i = $urandom_range(11);
            case ($urandom_range(3))
                0: d = 8'h00;
                1: d = 8'h01;
                2: d = 8'hFF;
                default: d = 8'($urandom);
            endcase
            wr(REG_OFFS[i], d);
            if ($urandom_range(3) == 0) wr(OFF_READBACK_SEL, 8'($urandom_range(1)));
            rd(REG_OFFS[i]);
            rd(OFF_READBACK_SEL);
            if ($urandom_range(1) == 1) upd();
            @(posedge clk);
            secondRefIndependent <= 1'($urandom_range(1));
            repeat (2) @(posedge clk);
            #1 chk_out();
        end
        wr(OFF_FIRST_REF_LOW, 8'h05);
        wr(OFF_FIRST_REF_HIGH, 8'h00);
        wr(OFF_SECOND_REF_LOW, 8'h00);
        wr(OFF_SECOND_REF_HIGH, 8'h00);
        wr(OFF_TEST_REF, 8'hFF);
        wr(OFF_FEEDBACK_LOW, 8'hFF);
        wr(OFF_FEEDBACK_HIGH, 8'h03);
        @(posedge clk);
        secondRefIndependent <= 1'b1;
        upd();
        repeat (2) @(posedge clk);
        div_chk(0, 5);
        div_chk(1, 1);
        div_chk(2, 63);
        div_chk(3, 1023);
        // second follows first when not independent
        wr(OFF_FIRST_REF_LOW, 8'h02);
        @(posedge clk);
        secondRefIndependent <= 1'b0;
        upd();
        repeat (2) @(posedge clk);
        div_chk(1, 2);
        wr(OFF_FEEDBACK_LOW, 8'h00);
        wr(OFF_FEEDBACK_HIGH, 8'h00);
        upd();
        div_chk(3, 1);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        act = RSTV;
        pend = RSTV;
        rbSel = 1'b0;
        #1 chk_out();
        rd(OFF_USER_TAG_HIGH);
        give_verdict();
    end
endmodule : input_pll_divider_pump_config_test
